// [common/cdr_map.svh]
/*
  Register offsets, configuration field positions and reset values of the
  per-socket DMA address and count register file.
  Assumes it is included by its bare name wherever these are needed.
*/
`ifndef CDR_MAP_SVH
`define CDR_MAP_SVH

// I/O offsets from the DMA base address.
`define CDR_OFS_ADDR0    4'h0
`define CDR_OFS_ADDR1    4'h1
`define CDR_OFS_ADDR2    4'h2
`define CDR_OFS_ADDR3    4'h3
`define CDR_OFS_CNT0     4'h4
`define CDR_OFS_CNT1     4'h5
`define CDR_OFS_CNT2     4'h6
`define CDR_OFS_CMD_STAT 4'h8
`define CDR_OFS_SW_REQ   4'h9
`define CDR_OFS_MODE     4'hB
`define CDR_OFS_CLEAR    4'hD
`define CDR_OFS_MASK     4'hF

// Slave configuration register fields.
`define CDR_CFG_BASE_MSB 31
`define CDR_CFG_BASE_LSB 4
`define CDR_CFG_EN32_BIT 3
`define CDR_CFG_WID_MSB  2
`define CDR_CFG_WID_LSB  1

// Reset values.
`define CDR_RST_BYTE     8'h00
`define CDR_RST_ADDR     32'h0000_0000
`define CDR_RST_CNT      24'h00_0000

`endif

// [common/cdr_pkg.sv]
/*
  Types shared by the DMA address and count register file.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package cdr_pkg;

  // Transfer width codes of the slave configuration width field.
  typedef enum logic [1:0] {
    CDR_WID_8  = 2'b00,
    CDR_WID_16 = 2'b01
  } cdr_width_t;

  // One address word handed to the memory side.
  typedef logic [32:0] cdr_xfer_word_t;

endpackage

// [rtl/cdr_fifo2.sv]
/*
  Two-entry buffer with valid and ready on both sides.
  Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
module cdr_fifo2 #(
  parameter int WIDTH = 33
) (
  // Clock and reset.
  input  wire logic             clk_sys,
  input  wire logic             rst,
  // Filling side.
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Draining side.
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);

  logic [WIDTH-1:0] slot0_q;
  logic [WIDTH-1:0] slot1_q;
  logic [1:0]       fill_q;
  logic             push;
  logic             pop;

  assign in_ready  = (fill_q != 2'h2);
  assign out_valid = (fill_q != 2'h0);
  assign out_data  = slot0_q;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      fill_q <= 2'h0;
    end else if (push && !pop) begin
      fill_q <= fill_q + 2'h1;
    end else if (pop && !push) begin
      fill_q <= fill_q - 2'h1;
    end
  end

  // The head slot always holds the oldest word so the output is a flop.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      slot0_q <= '0;
      slot1_q <= '0;
    end else if (push && pop) begin
      slot0_q <= in_data;
    end else if (push) begin
      if (fill_q == 2'h0) begin
        slot0_q <= in_data;
      end else begin
        slot1_q <= in_data;
      end
    end else if (pop) begin
      slot0_q <= slot1_q;
    end
  end

  a_fifo_bounded: assert property (@(posedge clk_sys) disable iff (rst)
    fill_q <= 2'h2) else $error("Buffer fill level out of range.");

endmodule

// [rtl/cdr_dma_regs.sv]
/*
  Per-socket DMA start/current address and transaction count registers,
  reached as I/O locations at the base held in the slave configuration
  register, with a two-entry buffer on the memory address path.
  Assumes the slave configuration word, the I/O strobes and the transaction
  requests all come from logic on clk_sys.
*/
// Summary of operation
// RULE_01: Decode registers at base from configuration 31:4.
// RULE_02: Address writes load base and current; reads current.
// RULE_03: Width field 2:1 selects 8 or 16 bit.
// RULE_04: Eight bit: bytes give address 7:0,15:8,23:16.
// RULE_05: Sixteen bit: low byte is 8:1, A0 low.
// RULE_06: Sixteen bit: second byte is address 16:9.
// RULE_07: Sixteen bit: third byte 23:17, bit0 ignored.
// RULE_08: Fourth byte gives 31:24 only when 32-bit enabled.
// RULE_09: Without 32-bit enable, address 31:24 is zero.
// RULE_10: Count decrements once per transaction, any size.
// RULE_11: Count runs through zero plus one step.
// RULE_12: Count reads return remaining transactions.
// RULE_13: High count byte used only with 32-bit enable.
// RULE_14: Low count is 7:0, mid count 15:8.
`timescale 1ns/1ps
`include "cdr_map.svh"
module cdr_dma_regs (
  // Clock and reset.
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // Slave configuration word.
  input  wire logic [31:0] slave_cfg,
  // I/O register access.
  input  wire logic [31:0] io_addr,
  input  wire logic        io_wr,
  input  wire logic        io_rd,
  input  wire logic [7:0]  io_wdata,
  output logic             io_hit,
  output logic [7:0]       io_rdata,
  output logic             io_rvalid,
  // Control from the rest of the DMA unit.
  input  wire logic        reload_base,
  // Transaction requests.
  input  wire logic        xact_valid,
  output logic             xact_ready,
  output logic             term_count,
  // Memory address stream.
  output logic             mem_valid,
  input  wire logic        mem_ready,
  output logic [31:0]      mem_addr,
  output logic             card_a0
);

  logic [31:0]             base_addr_q;
  logic [31:0]             cur_addr_q;
  logic [23:0]             base_cnt_q;
  logic [23:0]             cur_cnt_q;
  logic                    tc_q;
  logic [7:0]              io_rdata_q;
  logic                    io_rvalid_q;
  logic [3:0]              ofs;
  logic                    base_match;
  logic                    reg_hit;
  logic                    wr_hit;
  logic                    rd_hit;
  logic                    wr_addr;
  logic                    wr_cnt;
  logic                    en32;
  logic                    wide16;
  logic                    accept;
  logic                    at_zero;
  logic                    fifo_in_ready;
  cdr_pkg::cdr_xfer_word_t push_word;
  cdr_pkg::cdr_xfer_word_t fifo_out;

  // Memory address that the current register bytes stand for.
  function automatic logic [31:0] map_addr(input logic [31:0] cur,
                                           input logic        w16,
                                           input logic        e32);
    logic [7:0] hi;
    hi = e32 ? cur[31:24] : 8'h00; // [RULE_08] [RULE_09]
    if (w16) begin
      map_addr = {hi, cur[23:17], cur[15:8], cur[7:0], 1'b0}; // [RULE_05]
    end else begin
      map_addr = {hi, cur[23:0]}; // [RULE_04]
    end
  endfunction

  // Advance the current address by one transfer unit.
  function automatic logic [31:0] next_addr(input logic [31:0] cur,
                                            input logic        w16,
                                            input logic        e32);
    logic [24:0] sum;
    logic [7:0]  hi;
    sum = 25'h000_0000;
    if (w16) begin
      // Bit 0 of the third byte is skipped by the carry. [RULE_07]
      sum = {2'b00, cur[23:17], cur[15:0]} + 25'h000_0001;
      hi  = (e32 && sum[23]) ? cur[31:24] + 8'h01 : cur[31:24];
      next_addr = {hi, sum[22:16], cur[16], sum[15:0]}; // [RULE_06]
    end else begin
      sum = {1'b0, cur[23:0]} + 25'h000_0001;
      hi  = (e32 && sum[24]) ? cur[31:24] + 8'h01 : cur[31:24];
      next_addr = {hi, sum[23:0]};
    end
  endfunction

  // Width of the counter depends on the 32-bit enable.
  function automatic logic cnt_is_zero(input logic [23:0] cnt,
                                       input logic        e32);
    cnt_is_zero = e32 ? (cnt == 24'h00_0000) : (cnt[15:0] == 16'h0000);
  endfunction

  function automatic logic [23:0] cnt_next(input logic [23:0] cnt,
                                           input logic        e32);
    logic [15:0] low;
    low = cnt[15:0] - 16'h0001;
    cnt_next = e32 ? cnt - 24'h00_0001 : {cnt[23:16], low}; // [RULE_13]
  endfunction

  assign ofs        = io_addr[3:0];
  assign base_match = (io_addr[31:4] ==
                       slave_cfg[`CDR_CFG_BASE_MSB:`CDR_CFG_BASE_LSB]);
  assign reg_hit    = base_match && (ofs <= `CDR_OFS_CNT2); // [RULE_01]
  assign wr_hit     = io_wr && reg_hit;
  assign rd_hit     = io_rd && reg_hit;
  assign wr_addr    = wr_hit && (ofs <= `CDR_OFS_ADDR3);
  assign wr_cnt     = wr_hit && (ofs >= `CDR_OFS_CNT0);
  assign io_hit     = reg_hit;
  assign en32       = slave_cfg[`CDR_CFG_EN32_BIT];
  assign wide16     = (slave_cfg[`CDR_CFG_WID_MSB:`CDR_CFG_WID_LSB] ==
                       cdr_pkg::CDR_WID_16); // [RULE_03]
  assign at_zero    = cnt_is_zero(cur_cnt_q, en32);

  // A register write or reload stalls the step, so software never races it.
  assign xact_ready = !tc_q && !wr_hit && !reload_base && fifo_in_ready;
  assign accept     = xact_valid && xact_ready;
  assign push_word  = {(wide16 ? 1'b0 : cur_addr_q[0]),
                       map_addr(cur_addr_q, wide16, en32)};

  // Address bytes: a write loads base, and current too unless reload_base is high.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      base_addr_q <= `CDR_RST_ADDR;
    end else if (wr_addr) begin
      base_addr_q[{ofs[1:0], 3'b000} +: 8] <= io_wdata; // [RULE_02]
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cur_addr_q <= `CDR_RST_ADDR;
    end else if (reload_base) begin
      cur_addr_q <= base_addr_q;
    end else if (wr_addr) begin
      cur_addr_q[{ofs[1:0], 3'b000} +: 8] <= io_wdata; // [RULE_02]
    end else if (accept) begin
      cur_addr_q <= next_addr(cur_addr_q, wide16, en32);
    end
  end

  // Count bytes: low 7:0, mid 15:8, high 23:16.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      base_cnt_q <= `CDR_RST_CNT;
    end else if (wr_cnt) begin
      base_cnt_q[{ofs[1:0], 3'b000} +: 8] <= io_wdata; // [RULE_14]
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cur_cnt_q <= `CDR_RST_CNT;
    end else if (reload_base) begin
      cur_cnt_q <= base_cnt_q;
    end else if (wr_cnt) begin
      cur_cnt_q[{ofs[1:0], 3'b000} +: 8] <= io_wdata; // [RULE_14]
    end else if (accept) begin
      cur_cnt_q <= cnt_next(cur_cnt_q, en32); // [RULE_10]
    end
  end

  // Terminal count is the step taken from zero; set wins over a clear.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      tc_q <= 1'b0;
    end else if (accept && at_zero) begin
      tc_q <= 1'b1; // [RULE_11]
    end else if (wr_cnt || reload_base) begin
      tc_q <= 1'b0;
    end
  end

  assign term_count = tc_q;

  // Reads return current, advancing values one cycle after the strobe.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      io_rdata_q  <= `CDR_RST_BYTE;
      io_rvalid_q <= 1'b0;
    end else begin
      io_rvalid_q <= rd_hit;
      if (rd_hit) begin
        if (ofs <= `CDR_OFS_ADDR3) begin
          io_rdata_q <= cur_addr_q[{ofs[1:0], 3'b000} +: 8]; // [RULE_02]
        end else begin
          io_rdata_q <= cur_cnt_q[{ofs[1:0], 3'b000} +: 8]; // [RULE_12]
        end
      end
    end
  end

  assign io_rdata  = io_rdata_q;
  assign io_rvalid = io_rvalid_q;

  cdr_fifo2 #(
    .WIDTH     (33)
  ) u_addr_buf (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .in_valid  (accept),
    .in_ready  (fifo_in_ready),
    .in_data   (push_word),
    .out_valid (mem_valid),
    .out_ready (mem_ready),
    .out_data  (fifo_out)
  );

  assign mem_addr = fifo_out[31:0];
  assign card_a0  = fifo_out[32];

  a_decode_base: assert property ( // [RULE_01]
    @(posedge clk_sys) disable iff (rst)
    io_rvalid |-> $past(io_addr[31:4] == slave_cfg[31:4]))
    else $error("Read answered outside the base address.");

  a_write_loads: assert property ( // [RULE_02]
    @(posedge clk_sys) disable iff (rst)
    (wr_addr && !reload_base) |=> (cur_addr_q == base_addr_q ||
      cur_addr_q[{$past(ofs[1:0]), 3'b000} +: 8] == $past(io_wdata)))
    else $error("Address write did not load the current byte.");

  a_read_current: assert property ( // [RULE_02]
    @(posedge clk_sys) disable iff (rst)
    (rd_hit && ofs == `CDR_OFS_ADDR0) |=> io_rdata == $past(cur_addr_q[7:0]))
    else $error("Address read did not return the current byte.");

  a_map_eight: assert property ( // [RULE_04]
    @(posedge clk_sys) disable iff (rst)
    (accept && !wide16) |-> push_word[23:0] == cur_addr_q[23:0])
    else $error("Eight-bit address mapping wrong.");

  a_a0_low: assert property ( // [RULE_05]
    @(posedge clk_sys) disable iff (rst)
    (accept && wide16) |-> (push_word[32] == 1'b0 && push_word[0] == 1'b0 &&
      push_word[8:1] == cur_addr_q[7:0]))
    else $error("Sixteen-bit low byte mapping or A0 wrong.");

  a_map_sixteen: assert property ( // [RULE_06]
    @(posedge clk_sys) disable iff (rst)
    (accept && wide16) |-> push_word[16:9] == cur_addr_q[15:8])
    else $error("Sixteen-bit second byte mapping wrong.");

  a_third_byte: assert property ( // [RULE_07]
    @(posedge clk_sys) disable iff (rst)
    (accept && wide16) |-> push_word[23:17] == cur_addr_q[23:17])
    else $error("Sixteen-bit third byte mapping wrong.");

  a_high_used: assert property ( // [RULE_08]
    @(posedge clk_sys) disable iff (rst)
    (accept && en32) |-> push_word[31:24] == cur_addr_q[31:24])
    else $error("High address byte not used with 32-bit enable.");

  a_high_zero: assert property ( // [RULE_09]
    @(posedge clk_sys) disable iff (rst)
    (accept && !en32) |-> push_word[31:24] == 8'h00)
    else $error("Address 31:24 not zero without 32-bit enable.");

  a_count_step: assert property ( // [RULE_10]
    @(posedge clk_sys) disable iff (rst)
    accept |=> cur_cnt_q[15:0] == $past(cur_cnt_q[15:0]) - 16'h0001)
    else $error("Count did not step once per transaction.");

  a_tc_after_zero: assert property ( // [RULE_11]
    @(posedge clk_sys) disable iff (rst)
    (accept && at_zero) |=> (tc_q && !xact_ready)[*2])
    else $error("Terminal count missing after the step from zero.");

  a_count_read: assert property ( // [RULE_12]
    @(posedge clk_sys) disable iff (rst)
    (rd_hit && ofs == `CDR_OFS_CNT1) |=> io_rdata == $past(cur_cnt_q[15:8]))
    else $error("Count read did not return the remaining count.");

  a_high_ignored: assert property ( // [RULE_13]
    @(posedge clk_sys) disable iff (rst)
    (accept && !en32) |=> $stable(cur_cnt_q[23:16]) &&
      ($past(cur_cnt_q[15:0] != 16'h0000) || tc_q))
    else $error("High count byte moved or counted without 32-bit enable.");

  a_count_low: assert property ( // [RULE_14]
    @(posedge clk_sys) disable iff (rst)
    (wr_cnt && ofs == `CDR_OFS_CNT0 && !reload_base) |=>
      cur_cnt_q[7:0] == $past(io_wdata))
    else $error("Low count write did not land in count bits 7:0.");

endmodule

// [test/cdr_mem_sink.sv]
/*
  Memory-side sink model that takes mapped DMA addresses off the stream.
  Assumes the stream changes just after rising clk_sys edges.
*/
`timescale 1ns/1ps
module cdr_mem_sink (
  // Clock and reset.
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // Stall request from the bench.
  input  wire logic        stall,
  // Address stream.
  input  wire logic        mem_valid,
  output logic             mem_ready,
  input  wire logic [31:0] mem_addr,
  input  wire logic        card_a0
);
  // Popped words, oldest first, as {card_a0, mem_addr}.
  logic [32:0] got[$];

  always @(posedge clk_sys) begin
    if (rst) begin
      mem_ready <= 1'h0;
    end else begin
      // Ready trails the stall by a cycle, as a slow host would.
      mem_ready <= !stall;
      if (mem_valid && mem_ready) begin
        got.push_back({card_a0, mem_addr});
      end
    end
  end
endmodule

// [test/cdr_dma_regs_tb.sv]
/*
  Self-checking bench for the DMA address and count register file.
  Assumes the design files and cdr_mem_sink are compiled beforehand.
*/
`timescale 1ns/1ps
module cdr_dma_regs_tb;
  localparam logic [27:0] io_base = 28'h0001234;

  logic        clk_sys;
  logic        rst;
  logic [31:0] slave_cfg;
  logic [31:0] io_addr;
  logic        io_wr;
  logic        io_rd;
  logic [7:0]  io_wdata;
  logic        io_hit;
  logic [7:0]  io_rdata;
  logic        io_rvalid;
  logic        reload_base;
  logic        xact_valid;
  logic        xact_ready;
  logic        term_count;
  logic        mem_valid;
  logic        mem_ready;
  logic [31:0] mem_addr;
  logic        card_a0;
  logic        stall;
  int          error_cnt;
  int          n_compared;

  cdr_dma_regs cdr_dma_regs_i (
    .clk_sys(clk_sys), .rst(rst), .slave_cfg(slave_cfg),
    .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
    .io_wdata(io_wdata), .io_hit(io_hit), .io_rdata(io_rdata),
    .io_rvalid(io_rvalid), .reload_base(reload_base),
    .xact_valid(xact_valid), .xact_ready(xact_ready),
    .term_count(term_count), .mem_valid(mem_valid),
    .mem_ready(mem_ready), .mem_addr(mem_addr), .card_a0(card_a0)
  );

  cdr_mem_sink cdr_mem_sink_i (
    .clk_sys(clk_sys), .rst(rst), .stall(stall),
    .mem_valid(mem_valid), .mem_ready(mem_ready),
    .mem_addr(mem_addr), .card_a0(card_a0)
  );

  initial begin
    clk_sys = 1'h0;
    forever #2 clk_sys = ~clk_sys;
  end

  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [32:0] exp,
                     input logic [32:0] got);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cfg(input logic en32, input logic [1:0] wid);
    @(posedge clk_sys);
    slave_cfg <= {io_base, en32, wid, 1'h0};
  endtask

  task automatic wr(input logic [3:0] ofs, input logic [7:0] d);
    @(posedge clk_sys);
    io_wr <= 1'h1;
    io_addr <= {io_base, ofs};
    io_wdata <= d;
    @(posedge clk_sys);
    io_wr <= 1'h0;
  endtask

  // Loads the four address bytes, then the three count bytes.
  task automatic wr_set(input logic [31:0] a, input logic [23:0] c);
    for (int i = 0; i < 4; i++) wr(4'(i), a[8*i+:8]);
    for (int i = 0; i < 3; i++) wr(4'(i + 4), c[8*i+:8]);
  endtask

  task automatic rd(input logic [27:0] b, input logic [3:0] ofs,
                    input logic hit, input logic [7:0] exp);
    @(posedge clk_sys);
    io_rd <= 1'h1;
    io_addr <= {b, ofs};
    @(negedge clk_sys);
    chk("io_hit", {32'h0, hit}, {32'h0, io_hit});
    @(posedge clk_sys);
    io_rd <= 1'h0;
    #1;
    chk("io_rvalid", {32'h0, hit}, {32'h0, io_rvalid});
    if (hit) chk("io_rdata", {25'h0, exp}, {25'h0, io_rdata});
  endtask

  // Holds a request up until n of them have been taken.
  task automatic run(input int n);
    int acc;
    int lim;
    acc = 0;
    lim = 0;
    @(posedge clk_sys);
    xact_valid <= 1'h1;
    while (acc < n) begin
      @(negedge clk_sys);
      if (xact_ready === 1'h1) acc++;
      @(posedge clk_sys);
      lim++;
      if (lim > 200) begin
        error_cnt++;
        $display("[ERR] accepted expected %0d seen %0d", n, acc);
        summarize();
      end
    end
    xact_valid <= 1'h0;
  endtask

  task automatic pops(input int n);
    for (int i = 0; i < 50 && cdr_mem_sink_i.got.size() < n; i++) begin
      @(negedge clk_sys);
    end
    chk("popped", 33'(n), 33'(cdr_mem_sink_i.got.size()));
    if (cdr_mem_sink_i.got.size() < n) summarize();
  endtask

  task automatic t_reset();
    for (int i = 0; i < 7; i++) rd(io_base, 4'(i), 1'h1, 8'h00);
    rd(io_base, 4'h7, 1'h0, 8'h00);
    rd(io_base + 28'h1, 4'h0, 1'h0, 8'h00);
    $display("test reset done");
  endtask

  task automatic t_map8();
    cfg(1'h0, 2'h0);
    cdr_mem_sink_i.got.delete();
    wr_set(32'h78563412, 24'h070001);
    run(2);
    @(negedge clk_sys);
    chk("term_count", 33'h1, {32'h0, term_count});
    chk("xact_ready", 33'h0, {32'h0, xact_ready});
    pops(2);
    chk("word0", 33'h000563412, cdr_mem_sink_i.got[0]);
    chk("word1", 33'h100563413, cdr_mem_sink_i.got[1]);
    rd(io_base, 4'h0, 1'h1, 8'h14);
    rd(io_base, 4'h3, 1'h1, 8'h78);
    rd(io_base, 4'h4, 1'h1, 8'hFF);
    rd(io_base, 4'h5, 1'h1, 8'hFF);
    rd(io_base, 4'h6, 1'h1, 8'h07);
    $display("test map8 done");
  endtask

  task automatic t_map16();
    cfg(1'h1, 2'h1);
    cdr_mem_sink_i.got.delete();
    wr_set(32'h9A35CDAB, 24'h000002);
    @(posedge clk_sys);
    stall <= 1'h1;
    // The sink stalls so that the buffer fills and must refuse.
    fork
      run(3);
      begin
        repeat (8) @(negedge clk_sys);
        chk("full_ready", 33'h0, {32'h0, xact_ready});
        chk("mem_valid", 33'h1, {32'h0, mem_valid});
        @(posedge clk_sys);
        stall <= 1'h0;
      end
    join
    @(negedge clk_sys);
    chk("term_count", 33'h1, {32'h0, term_count});
    pops(3);
    for (int i = 0; i < 3; i++) begin
      chk("word", {1'h0, 32'h9A359B56 + 32'(2 * i)},
          cdr_mem_sink_i.got[i]);
    end
    rd(io_base, 4'h0, 1'h1, 8'hAE);
    rd(io_base, 4'h6, 1'h1, 8'hFF);
    rd(io_base, 4'h4, 1'h1, 8'hFF);
    @(posedge clk_sys);
    reload_base <= 1'h1;
    @(posedge clk_sys);
    reload_base <= 1'h0;
    @(negedge clk_sys);
    chk("term_count", 33'h0, {32'h0, term_count});
    rd(io_base, 4'h0, 1'h1, 8'hAB);
    rd(io_base, 4'h4, 1'h1, 8'h02);
    $display("test map16 done");
  endtask

  // Width codes 10 and 11 act as 8-bit; byte 3 takes the carry only
  // with the 32-bit enable.
  task automatic t_carry();
    cfg(1'h0, 2'h2);
    cdr_mem_sink_i.got.delete();
    wr_set(32'h11FFFFFF, 24'h000001);
    run(2);
    pops(2);
    chk("word0", 33'h100FFFFFF, cdr_mem_sink_i.got[0]);
    chk("word1", 33'h000000000, cdr_mem_sink_i.got[1]);
    rd(io_base, 4'h3, 1'h1, 8'h11);
    cfg(1'h1, 2'h3);
    cdr_mem_sink_i.got.delete();
    @(posedge clk_sys);
    reload_base <= 1'h1;
    @(posedge clk_sys);
    reload_base <= 1'h0;
    run(2);
    pops(2);
    chk("word2", 33'h111FFFFFF, cdr_mem_sink_i.got[0]);
    chk("word3", 33'h012000000, cdr_mem_sink_i.got[1]);
    rd(io_base, 4'h3, 1'h1, 8'h12);
    $display("test carry done");
  endtask

  initial begin
    error_cnt = 0;
    n_compared = 0;
    rst = 1'h1;
    slave_cfg = {io_base, 4'h0};
    io_addr = 32'h0;
    io_wr = 1'h0;
    io_rd = 1'h0;
    io_wdata = 8'h00;
    reload_base = 1'h0;
    xact_valid = 1'h0;
    stall = 1'h0;
    repeat (4) @(posedge clk_sys);
    rst <= 1'h0;
    t_reset();
    t_map8();
    t_map16();
    t_carry();
    summarize();
  end
endmodule
